// ---- inc/olg_pkg.sv ----
// Constants and carrier types of the general output logic and input functions block.
package olg_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int DELAY_UNIT_NS = 1000;
  localparam int CYC_PER_UNIT  = (DELAY_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W         = 22;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_IN_CFG   = 8'h00;
  localparam logic [7:0] ADDR_RAIL_CFG = 8'h04;
  localparam logic [7:0] ADDR_FUNC     = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_PINS     = 8'h10;
  localparam logic [7:0] ADDR_OUT_BASE = 8'h40;
  localparam logic [7:0] OUT_STRIDE    = 8'h10;
  localparam logic [1:0] SUB_CFG       = 2'h0;
  localparam logic [1:0] SUB_TERM0     = 2'h1;
  localparam logic [1:0] SUB_TERM1     = 2'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int IN_DEF_POS      = 8;
  localparam int RAIL_VMON_POS   = 16;
  localparam int CMD_CLR_POS     = 0;
  localparam int STAT_LOGIC_POS  = 8;
  localparam int STAT_FLT_POS    = 20;
  localparam int STAT_DBG_POS    = 21;
  localparam int STAT_FBUS_POS   = 22;
  localparam int STAT_SHUT_POS   = 23;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_POL    = 8'hFF;
  localparam logic       RST_OE_N   = 1'b1;

  // ----------------------------------------------------------------
  // Rail status types: live codes first, latched codes after them
  // ----------------------------------------------------------------
  localparam int         N_LIVE      = 17;
  localparam int         N_LATCH     = 14;
  localparam logic [4:0] TYP_PGOOD   = 5'h00;
  localparam logic [4:0] TYP_LATCH0  = 5'h11;
  localparam logic [4:0] LATCH_BASE  = 5'h03;

  // ----------------------------------------------------------------
  // Carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        en;
    logic        od;
    logic        pol;
    logic        sm;
    logic        ign;
    logic        dly_dn;
    logic        dly_up;
    logic [15:0] dly;
  } olg_out_cfg_t;

  typedef struct packed {
    logic [4:0] typ;
    logic [9:0] rail;
    logic [7:0] in_m;
    logic [7:0] out_m;
  } olg_term_t;

  typedef struct packed {
    logic       vld;
    logic [2:0] idx;
  } olg_sel_t;

  typedef struct packed {
    logic     pin_opt;
    logic     shut_opt;
    olg_sel_t debug;
    olg_sel_t dir;
    olg_sel_t men;
    olg_sel_t clr;
    olg_sel_t flt;
  } olg_func_t;

endpackage

// ---- design/olg_core.sv ----
// General output logic, output delays and special input functions of a rail sequencer.
`timescale 1ns/10ps

module olg_core
  import olg_pkg::*;
#(
  parameter int NUM_OUT  = 10,
  parameter int NUM_IN   = 8,
  parameter int NUM_RAIL = 10
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               sys_rst,
  // Register port
  input  wire logic [7:0]                         addr,
  input  wire logic [31:0]                        wdata,
  input  wire logic                               wr,
  input  wire logic                               rd,
  output logic      [31:0]                        rdata,
  // Input pins
  input  wire logic [NUM_IN-1:0]                  general_input,
  // Output pins
  output logic      [NUM_OUT-1:0]                 general_output_o,
  output logic      [NUM_OUT-1:0]                 general_output_oe_n,
  // Fault bus pin
  input  wire logic                               fault_pin_i,
  output logic                                    fault_pin_o,
  output logic                                    fault_pin_oe_n,
  // Rail monitors
  input  wire logic [N_LIVE-1:0][NUM_RAIL-1:0]    rail_live,
  input  wire logic                               rail_fault_evt,
  input  wire logic                               comm_error_evt,
  // System side
  output logic      [7:0]                         seq_dep,
  output logic      [NUM_RAIL-1:0]                margin_active,
  output logic      [NUM_RAIL-1:0]                margin_low,
  output logic      [2:0]                         pin_sel_code,
  output logic                                    fault_shutdown,
  output logic                                    alert,
  output logic                                    fault_log,
  output logic                                    debug_mode
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (NUM_OUT < 8 || NUM_OUT > 12 || NUM_IN < 3 || NUM_IN > 8 || NUM_RAIL < 1 ||
      NUM_RAIL > 10) begin : g_bad_param
    $error("olg_core: parameter out of the supported range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NUM_IN-1:0]                    pol;
    logic [NUM_IN-1:0]                    defm;
    logic [NUM_RAIL-1:0]                  mrg_en;
    logic [NUM_RAIL-1:0]                  vmon;
    olg_func_t                            func;
    olg_out_cfg_t [NUM_OUT-1:0]           ocfg;
    olg_term_t [NUM_OUT-1:0][1:0]         term;
    logic [NUM_IN-1:0]                    s1;
    logic [NUM_IN-1:0]                    s2;
    logic [NUM_IN-1:0]                    s3;
    logic [NUM_IN-1:0]                    inp;
    logic [2:0]                           fb;
    logic                                 fbus;
    logic [N_LIVE-1:0][NUM_RAIL-1:0]      lat;
    logic [NUM_OUT-1:0]                   lg;
    logic [NUM_OUT-1:0]                   busy;
    logic [NUM_OUT-1:0]                   tgt;
    logic [NUM_OUT-1:0][CNT_W-1:0]        cnt;
    logic [NUM_OUT-1:0]                   pin_o;
    logic [NUM_OUT-1:0]                   pin_oe_n;
    logic [31:0]                          rdata;
    logic                                 gpi_flt;
    logic                                 shut;
    logic                                 fpin_o;
    logic                                 fpin_oe_n;
    logic                                 alert;
    logic                                 flog;
    logic                                 dbg;
    logic [NUM_RAIL-1:0]                  m_act;
    logic [NUM_RAIL-1:0]                  m_low;
    logic [2:0]                           psel;
    logic [7:0]                           dep;
  } olg_state_t;

  olg_state_t q;
  olg_state_t d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Asserted level of the input that a special function is bound to.
  function automatic logic sel_in(olg_sel_t s, logic [NUM_IN-1:0] a);
    return s.vld && (32'(s.idx) < NUM_IN) && a[s.idx];
  endfunction

  // Flags of one status type over all rails, padded to ten rails.
  function automatic logic [9:0] type_row(logic [4:0] typ,
                                          logic [N_LIVE-1:0][NUM_RAIL-1:0] live,
                                          logic [N_LIVE-1:0][NUM_RAIL-1:0] lat,
                                          logic [NUM_RAIL-1:0] vmon);
    logic [9:0] row;
    row = '0;
    if (32'(typ) < N_LIVE) begin
      row[NUM_RAIL-1:0] = live[typ];
      if (typ == TYP_PGOOD) begin
        row[NUM_RAIL-1:0] = live[typ] & vmon;
      end
    end else if (32'(typ) < N_LIVE + N_LATCH) begin
      row[NUM_RAIL-1:0] = lat[5'(typ - TYP_LATCH0 + LATCH_BASE)];
    end
    return row;
  endfunction

  // One AND term; an empty term is false.
  function automatic logic term_eval(olg_term_t t, logic [7:0] lg8, logic [7:0] in8,
                                     logic [9:0] row);
    logic any;
    logic all;
    any = |{t.out_m, t.in_m, t.rail};
    all = &(~t.out_m | lg8) & &(~t.in_m | in8) & &(~t.rail | row);
    return any & all;
  endfunction

  // Delay in clock cycles.
  function automatic logic [CNT_W-1:0] dly_cyc(logic [15:0] dv);
    return CNT_W'(32'(dv) * CYC_PER_UNIT);
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [NUM_IN-1:0]  asr;
    logic [7:0]         in8;
    logic [7:0]         lg8;
    logic               clr;
    logic               flt;
    logic               men;
    logic               mdir;
    logic               r0;
    logic               r1;
    logic               r;
    logic               use_dly;
    logic               lvl;
    logic [CNT_W-1:0]   lim;
    logic [31:0]        w;
    logic [3:0]         oi;
    logic [1:0]         sub;
    int                 k;
    asr     = '0;
    in8     = '0;
    lg8     = '0;
    clr     = 1'b0;
    flt     = 1'b0;
    men     = 1'b0;
    mdir    = 1'b0;
    r0      = 1'b0;
    r1      = 1'b0;
    r       = 1'b0;
    use_dly = 1'b0;
    lvl     = 1'b0;
    lim     = '0;
    w       = '0;
    oi      = '0;
    sub     = '0;
    k       = 0;
    d       = q;
    d.rdata = '0;

    // Input pins pass three flops; a change counts once stages two and three agree.
    d.s1  = general_input;
    d.s2  = q.s1;
    d.s3  = q.s2;
    d.inp = (q.s2 & q.s3) | (q.inp & (q.s2 ^ q.s3));
    d.fb  = {fault_pin_i, q.fb[2:1]};
    if (q.fb[1] == q.fb[0]) begin
      d.fbus = ~q.fb[0];
    end
    asr = ~(q.inp ^ q.pol);
    in8[NUM_IN-1:0] = asr;

    // Special input functions.
    d.dbg = sel_in(q.func.debug, asr);
    men   = sel_in(q.func.men, asr);
    mdir  = sel_in(q.func.dir, asr);
    flt   = q.func.flt.vld & ~sel_in(q.func.flt, asr);
    clr   = sel_in(q.func.clr, asr) | (wr && addr == ADDR_STATUS && wdata[CMD_CLR_POS]);

    // Latched types: a new flag wins over a clear in the same cycle.
    for (int t = 0; t < N_LIVE; t++) begin
      d.lat[t] = (q.lat[t] & {NUM_RAIL{~clr}}) | rail_live[t];
    end

    d.m_act = men ? q.mrg_en : '0;
    d.m_low = d.m_act & {NUM_RAIL{mdir}};

    k = 0;
    d.psel = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (q.defm[i] && k < 3) begin
        d.psel[k[1:0]] = asr[i];
        k = k + 1;
      end
    end

    // Input fault: level response, never retried, suppressed in debug mode.
    d.gpi_flt   = flt & ~d.dbg;
    d.shut      = d.gpi_flt & (q.func.shut_opt | q.func.pin_opt);
    d.fpin_o    = 1'b0;
    d.fpin_oe_n = ~(q.func.pin_opt & ~d.dbg & (flt | rail_fault_evt));
    d.flog      = ~d.dbg & ((d.gpi_flt & ~q.gpi_flt) | rail_fault_evt);
    d.alert     = d.flog | comm_error_evt;

    // Output logic and delays.
    lg8 = q.lg[7:0];
    for (int i = 0; i < NUM_OUT; i++) begin
      r0 = term_eval(q.term[i][0], lg8, in8,
                     type_row(q.term[i][0].typ, rail_live, q.lat, q.vmon));
      r1 = term_eval(q.term[i][1], lg8, in8,
                     type_row(q.term[i][1].typ, rail_live, q.lat, q.vmon));
      if (q.ocfg[i].sm) begin
        r = q.lg[i] ? r0 : r1;
      end else begin
        r = r0 | r1;
      end
      use_dly = r ? q.ocfg[i].dly_up : q.ocfg[i].dly_dn;
      lim     = dly_cyc(q.ocfg[i].dly);
      if (q.busy[i]) begin
        d.cnt[i] = q.cnt[i] + 1'b1;
        if (q.cnt[i] + 1'b1 >= lim) begin
          d.lg[i]   = q.tgt[i];
          d.busy[i] = 1'b0;
          d.cnt[i]  = '0;
        end
      end else if (r != q.lg[i] && use_dly && lim != '0) begin
        if (q.ocfg[i].ign) begin
          d.busy[i] = 1'b1;
          d.tgt[i]  = r;
          d.cnt[i]  = '0;
        end else begin
          d.cnt[i] = q.cnt[i] + 1'b1;
          if (q.cnt[i] + 1'b1 >= lim) begin
            d.lg[i]  = r;
            d.cnt[i] = '0;
          end
        end
      end else begin
        d.lg[i]  = r;
        d.cnt[i] = '0;
      end
      lvl           = ~(d.lg[i] ^ q.ocfg[i].pol);
      d.pin_o[i]    = lvl;
      d.pin_oe_n[i] = ~q.ocfg[i].en | (q.ocfg[i].od & lvl);
    end
    d.dep = d.lg[7:0];

    // Register writes.
    oi  = 4'((addr - ADDR_OUT_BASE) >> 4);
    sub = addr[3:2];
    if (wr) begin
      if (addr == ADDR_IN_CFG) begin
        d.pol  = wdata[NUM_IN-1:0];
        d.defm = wdata[IN_DEF_POS+:NUM_IN];
      end else if (addr == ADDR_RAIL_CFG) begin
        d.mrg_en = wdata[NUM_RAIL-1:0];
        d.vmon   = wdata[RAIL_VMON_POS+:NUM_RAIL];
      end else if (addr == ADDR_FUNC) begin
        d.func = olg_func_t'(wdata[$bits(olg_func_t)-1:0]);
      end else if (addr >= ADDR_OUT_BASE && 32'(oi) < NUM_OUT && addr[1:0] == 2'h0) begin
        if (sub == SUB_CFG) begin
          d.ocfg[oi] = olg_out_cfg_t'(wdata[$bits(olg_out_cfg_t)-1:0]);
        end else if (sub == SUB_TERM0) begin
          d.term[oi][0] = olg_term_t'(wdata[$bits(olg_term_t)-1:0]);
        end else if (sub == SUB_TERM1) begin
          d.term[oi][1] = olg_term_t'(wdata[$bits(olg_term_t)-1:0]);
        end
      end
    end

    // Register reads; unmapped addresses read zero.
    if (rd) begin
      if (addr == ADDR_IN_CFG) begin
        w[NUM_IN-1:0]          = q.pol;
        w[IN_DEF_POS+:NUM_IN]  = q.defm;
      end else if (addr == ADDR_RAIL_CFG) begin
        w[NUM_RAIL-1:0]           = q.mrg_en;
        w[RAIL_VMON_POS+:NUM_RAIL] = q.vmon;
      end else if (addr == ADDR_FUNC) begin
        w[$bits(olg_func_t)-1:0] = q.func;
      end else if (addr == ADDR_STATUS) begin
        w[NUM_IN-1:0]               = asr;
        w[STAT_LOGIC_POS+:NUM_OUT]  = q.lg;
        w[STAT_FLT_POS]             = q.gpi_flt;
        w[STAT_DBG_POS]             = q.dbg;
        w[STAT_FBUS_POS]            = q.fbus;
        w[STAT_SHUT_POS]            = q.shut;
      end else if (addr == ADDR_PINS) begin
        w[NUM_OUT-1:0] = q.pin_o;
      end else if (addr >= ADDR_OUT_BASE && 32'(oi) < NUM_OUT && addr[1:0] == 2'h0) begin
        if (sub == SUB_CFG) begin
          w[$bits(olg_out_cfg_t)-1:0] = q.ocfg[oi];
        end else if (sub == SUB_TERM0) begin
          w[$bits(olg_term_t)-1:0] = q.term[oi][0];
        end else if (sub == SUB_TERM1) begin
          w[$bits(olg_term_t)-1:0] = q.term[oi][1];
        end
      end
      d.rdata = w;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q           <= '0;
      q.pol       <= RST_POL[NUM_IN-1:0];
      q.pin_oe_n  <= {NUM_OUT{RST_OE_N}};
      q.fpin_oe_n <= RST_OE_N;
      q.fb        <= {3{RST_OE_N}};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata               = q.rdata;
  assign general_output_o    = q.pin_o;
  assign general_output_oe_n = q.pin_oe_n;
  assign fault_pin_o         = q.fpin_o;
  assign fault_pin_oe_n      = q.fpin_oe_n;
  assign seq_dep             = q.dep;
  assign margin_active       = q.m_act;
  assign margin_low          = q.m_low;
  assign pin_sel_code        = q.psel;
  assign fault_shutdown      = q.shut;
  assign alert               = q.alert;
  assign fault_log           = q.flog;
  assign debug_mode          = q.dbg;

endmodule // olg_core

// ---- verification/olg_core_assertions.sv ----
// Concurrent checks on the ports of the general output logic block.
`timescale 1ns/10ps

module olg_core_assertions
  import olg_pkg::*;
#(
  parameter int NUM_OUT  = 10,
  parameter int NUM_IN   = 8,
  parameter int NUM_RAIL = 10
) (
  // Clock and reset
  input wire logic                            clk,
  input wire logic                            sys_rst,
  // Register port
  input wire logic [7:0]                      addr,
  input wire logic [31:0]                     wdata,
  input wire logic                            wr,
  input wire logic                            rd,
  input wire logic [31:0]                     rdata,
  // Pins
  input wire logic [NUM_IN-1:0]               general_input,
  input wire logic [NUM_OUT-1:0]              general_output_o,
  input wire logic [NUM_OUT-1:0]              general_output_oe_n,
  input wire logic                            fault_pin_i,
  input wire logic                            fault_pin_o,
  input wire logic                            fault_pin_oe_n,
  // Monitors and system side
  input wire logic [N_LIVE-1:0][NUM_RAIL-1:0] rail_live,
  input wire logic                            rail_fault_evt,
  input wire logic                            comm_error_evt,
  input wire logic [7:0]                      seq_dep,
  input wire logic [NUM_RAIL-1:0]             margin_active,
  input wire logic [NUM_RAIL-1:0]             margin_low,
  input wire logic [2:0]                      pin_sel_code,
  input wire logic                            fault_shutdown,
  input wire logic                            alert,
  input wire logic                            fault_log,
  input wire logic                            debug_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Debug mode seen on two edges in a row, so pipeline stages agree.
  sequence dbg_held;
    debug_mode ##1 debug_mode;
  endsequence

  rd_idle_a: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("stray read data");
  pin_reset_a: assert property ($fell(sys_rst) |-> &general_output_oe_n && fault_pin_oe_n)
    else $error("pins driven after reset");
  fpin_low_a: assert property (fault_pin_o == 1'b0)
    else $error("fault drive level high");
  margin_dir_a: assert property ((margin_low & ~margin_active) == '0)
    else $error("margin low on unmargined rail");
  dbg_log_a: assert property (dbg_held |-> !fault_log)
    else $error("fault logged in debug mode");
  dbg_shut_a: assert property (dbg_held |-> !fault_shutdown)
    else $error("fault shutdown in debug mode");
  dbg_bus_a: assert property (dbg_held |-> fault_pin_oe_n)
    else $error("fault bus pulled in debug mode");
  comm_alert_a: assert property (debug_mode && comm_error_evt |-> ##[1:3] alert)
    else $error("no alert on comm error");
  rail_log_a: assert property (!debug_mode && rail_fault_evt |-> ##[1:3] fault_log)
    else $error("rail fault not logged");

  cover property (debug_mode && comm_error_evt);
endmodule // olg_core_assertions

bind olg_core olg_core_assertions #(.NUM_OUT(NUM_OUT), .NUM_IN(NUM_IN), .NUM_RAIL(NUM_RAIL))
  u_olg_core_assertions (.*);

// ---- verification/olg_board_model.sv ----
// Board model: input pins, rail monitors and pulled-up output and fault bus wires.
`timescale 1ns/10ps

module olg_board_model
  import olg_pkg::*;
#(
  parameter int NUM_OUT  = 10,
  parameter int NUM_RAIL = 10
) (
  // Clock and stimulus from the bench
  input  wire logic                            clk,
  input  wire logic [7:0]                      pin_set,
  input  wire logic [N_LIVE-1:0][NUM_RAIL-1:0] rail_set,
  input  wire logic                            rail_flt,
  input  wire logic                            comm_flt,
  // Device pins
  input  wire logic [NUM_OUT-1:0]              general_output_o,
  input  wire logic [NUM_OUT-1:0]              general_output_oe_n,
  input  wire logic                            fault_pin_o,
  input  wire logic                            fault_pin_oe_n,
  // Signals seen by the device and the bench
  output logic      [7:0]                      general_input,
  output logic      [N_LIVE-1:0][NUM_RAIL-1:0] rail_live,
  output logic                                 rail_fault_evt,
  output logic                                 comm_error_evt,
  output logic                                 fault_pin_i,
  output logic      [NUM_OUT-1:0]              out_level
);
  // Monitors update on the device clock, one stage behind the bench.
  always_ff @(posedge clk) begin
    general_input  <= pin_set;
    rail_live      <= rail_set;
    rail_fault_evt <= rail_flt;
    comm_error_evt <= comm_flt;
  end

  // Released wires float to their pull-up.
  assign out_level   = (general_output_o & ~general_output_oe_n) | general_output_oe_n;
  assign fault_pin_i = fault_pin_oe_n | fault_pin_o;
endmodule // olg_board_model

// ---- verification/olg_core_bench.sv ----
// Self-checking bench of the general output logic block.
`timescale 1ns/10ps

module olg_core_bench;
  import olg_pkg::*;
  localparam int NR = 10;
  logic                     clk = 1'b0, sys_rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic [7:0]               addr = 8'h00, pin_set = 8'h00, general_input, seq_dep;
  logic [31:0]              wdata = 32'h0, rdata;
  logic [N_LIVE-1:0][NR-1:0] rail_set = '0, rail_live;
  logic                     rail_flt = 1'b0, comm_flt = 1'b0, rail_fault_evt, comm_error_evt;
  logic                     fault_pin_i, fault_pin_o, fault_pin_oe_n, fault_shutdown;
  logic                     alert, fault_log, debug_mode;
  logic [9:0]               general_output_o, general_output_oe_n, out_level;
  logic [NR-1:0]            margin_active, margin_low;
  logic [2:0]               pin_sel_code;
  int                       n_mismatch = 0, total_checks = 0, cyc = 0, cnt;

  olg_core u_olg_core (.*);
  olg_board_model u_olg_board_model (.clk(clk), .pin_set(pin_set), .rail_set(rail_set),
    .rail_flt(rail_flt), .comm_flt(comm_flt), .general_output_o(general_output_o),
    .general_output_oe_n(general_output_oe_n), .fault_pin_o(fault_pin_o),
    .fault_pin_oe_n(fault_pin_oe_n), .general_input(general_input), .rail_live(rail_live),
    .rail_fault_evt(rail_fault_evt), .comm_error_evt(comm_error_evt),
    .fault_pin_i(fault_pin_i), .out_level(out_level));

  initial begin
    forever #10 clk = ~clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, exp, what);
  endtask

  // Sets the pins and waits for the logic to settle.
  task automatic pins(input logic [7:0] v);
    @(posedge clk);
    pin_set <= v;
    repeat (10) @(posedge clk);
    #1;
  endtask

  task automatic out0(input logic exp, input string what);
    chk(32'(general_output_o[0]), 32'(exp), what);
  endtask

  // Pulses input 0 for 20 cycles, then counts cycles of output 0 high.
  task automatic pulse_count(input int win);
    @(posedge clk);
    pin_set <= 8'h01;
    repeat (20) @(posedge clk);
    pin_set <= 8'h00;
    cnt = 0;
    repeat (win) begin
      @(posedge clk);
      #1 if (general_output_o[0] === 1'b1) cnt++;
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    chk(32'(general_output_oe_n), 32'h3FF, "pins released after reset");
    rd_chk(ADDR_IN_CFG, 32'h000000FF, "input config reset");
    wr_reg(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0, "unmapped read");
    wr_reg(ADDR_IN_CFG, 32'h0000FFFF);
    rd_chk(ADDR_IN_CFG, 32'h0000FFFF, "input config readback");
    $display("t_regs done");
  endtask

  task automatic t_logic();
    wr_reg(8'h44, 32'h00000100);
    wr_reg(8'h40, 32'h00500000);
    pins(8'h01);
    out0(1'b1, "and term true");
    chk(32'(general_output_oe_n[0]), 32'h0, "pin driven");
    chk(32'(seq_dep[0]), 32'h1, "logic state dependency");
    pins(8'h05);
    chk(32'(pin_sel_code), 32'h5, "pin select code");
    wr_reg(ADDR_IN_CFG, 32'h0000FFFE);
    pins(8'h00);
    out0(1'b1, "active low input asserted");
    wr_reg(ADDR_IN_CFG, 32'h0000FFFF);
    wr_reg(8'h40, 32'h00700000);
    pins(8'h01);
    chk(32'(general_output_oe_n[0]), 32'h1, "open drain high released");
    chk(32'(out_level[0]), 32'h1, "open drain pulled up");
    pins(8'h00);
    chk(32'(out_level[0]), 32'h0, "open drain low");
    $display("t_logic done");
  endtask

  task automatic t_delay();
    wr_reg(8'h40, 32'h00510001);
    pins(8'h00);
    pulse_count(80);
    chk(32'(cnt), 32'h0, "short pulse filtered");
    pins(8'h01);
    out0(1'b0, "assertion delayed");
    repeat (50) @(posedge clk);
    #1 out0(1'b1, "assertion after delay");
    pins(8'h00);
    out0(1'b0, "deassertion not delayed");
    wr_reg(8'h40, 32'h00570001);
    pins(8'h00);
    pulse_count(200);
    chk(32'(cnt >= 50 && cnt < 200), 32'h1, "ignore mode pulse width");
    $display("t_delay done");
  endtask

  task automatic t_sm();
    wr_reg(8'h48, 32'h00000200);
    wr_reg(8'h40, 32'h00580000);
    pins(8'h01);
    out0(1'b0, "false state uses term 1");
    pins(8'h03);
    out0(1'b1, "term 1 sets");
    pins(8'h01);
    out0(1'b1, "true state uses term 0");
    $display("t_sm done");
  endtask

  task automatic t_rail();
    wr_reg(8'h48, 32'h0);
    wr_reg(8'h44, 32'h00010100);
    wr_reg(8'h40, 32'h00500000);
    wr_reg(ADDR_RAIL_CFG, 32'h00000001);
    rail_set[TYP_PGOOD][0] <= 1'b1;
    pins(8'h01);
    out0(1'b0, "unmonitored power good unused");
    wr_reg(ADDR_RAIL_CFG, 32'h00010001);
    pins(8'h01);
    out0(1'b1, "monitored power good used");
    wr_reg(8'h44, 32'h44010000);
    pins(8'h00);
    @(posedge clk);
    rail_set[3][0] <= 1'b1;
    repeat (2) @(posedge clk);
    rail_set[3][0] <= 1'b0;
    pins(8'h00);
    out0(1'b1, "latched status holds");
    wr_reg(ADDR_STATUS, 32'h1);
    pins(8'h00);
    out0(1'b0, "bus clear of latch");
    @(posedge clk);
    rail_set[3][0] <= 1'b1;
    repeat (2) @(posedge clk);
    rail_set[3][0] <= 1'b0;
    $display("t_rail done");
  endtask

  task automatic t_func();
    pins(8'h08);
    wr_reg(ADDR_FUNC, 32'h003CA9DB);
    pins(8'h28);
    out0(1'b0, "input clear of latch");
    pins(8'h0A);
    chk(32'(margin_active[0]), 32'h1, "margin enable");
    chk(32'(margin_low[0]), 32'h0, "margin high");
    pins(8'h0E);
    chk(32'(margin_low[0]), 32'h1, "margin low");
    pins(8'h18);
    chk(32'(debug_mode), 32'h1, "debug input");
    pins(8'h10);
    chk(32'(fault_shutdown), 32'h0, "fault ignored in debug");
    @(posedge clk);
    comm_flt <= 1'b1; rail_flt <= 1'b1;
    @(posedge clk);
    comm_flt <= 1'b0; rail_flt <= 1'b0;
    pins(8'h00);
    chk(32'(fault_shutdown), 32'h1, "input fault shutdown");
    chk(32'(fault_pin_oe_n), 32'h0, "fault bus pulled");
    @(posedge clk);
    rail_flt <= 1'b1;
    @(posedge clk);
    rail_flt <= 1'b0;
    repeat (4) @(posedge clk);
    $display("t_func done");
  endtask

  // ----------------------------------------------------------------
  // Main sequence and time limit
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    repeat (8) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 t_regs();
    t_logic();
    t_delay();
    t_sm();
    t_rail();
    t_func();
    report_and_stop();
  end
endmodule // olg_core_bench
